// ==== logic/psc_strap_latch.sv ====
// Purpose: latch board straps at reset and seed the transceiver configuration
// Assumes: strap pins synchronous to core_clk; reset held at least two enabled edges
// Notes: the captured value is the pin level on the last enabled edge with reset high
`timescale 1ns/1ns
module psc_strap_latch
    import psc_pkg::*;
#(
    parameter int unsigned ADDR_PINS = PSC_ADDR_PINS // strapped address bits
)
(
    input wire logic core_clk, // core clock, 20 MHz
    input wire logic reset, // synchronous reset, active high
    input wire logic clk_en, // freezes all state while low
    input wire logic [ADDR_PINS-1:0] station_addr_strap, // address strap levels
    input wire logic [2:0] mode_strap, // interface select strap levels
    input wire logic iso_strap, // isolate strap level
    input wire logic speed_strap, // speed or far-end fault strap level
    input wire logic duplex_strap, // duplex strap level
    input wire logic autoneg_enable_strap, // auto-negotiation strap level
    input wire logic fiber_select, // copper low, fiber high
    output logic strap_oe_n, // high while straps are sampled, low once pins released
    output logic cfg_valid, // straps captured and stable
    output logic [4:0] station_addr, // management station address
    output logic [2:0] mode_code, // latched interface select
    output logic mode_mii, // mii family selected
    output logic mode_rmii, // rmii family selected
    output logic mode_smii, // smii selected
    output logic mode_b2b, // back-to-back variant
    output logic mode_pre_restore, // 100m preamble restore
    output logic mode_reserved, // reserved select code
    output logic fiber_mode, // latched fiber selection
    output logic far_end_fault_enable, // fiber far-end fault enable
    output logic [15:0] ctl_default, // control word default
    output logic [15:0] adv_default // advertisement word default
);
    typedef struct packed {
        logic oe_n;
        logic valid;
        logic [4:0] addr;
        logic [2:0] mode;
        logic mii;
        logic rmii;
        logic smii;
        logic b2b;
        logic pre;
        logic rsv;
        logic fiber;
        logic fef;
        logic [15:0] ctl;
        logic [15:0] adv;
    } psc_state_s;

    psc_state_s st_q; // registered state
    psc_state_s st_d; // next state
    logic dec_mii; // decoded mii
    logic dec_rmii; // decoded rmii
    logic dec_smii; // decoded smii
    logic dec_b2b; // decoded back-to-back
    logic dec_pre; // decoded preamble restore
    logic dec_rsv; // decoded reserved

    // decode the live select pins so the flags land with the code
    psc_mode_decode u_dec (
        .mode_code(mode_strap),
        .sel_mii(dec_mii),
        .sel_rmii(dec_rmii),
        .sel_smii(dec_smii),
        .sel_b2b(dec_b2b),
        .sel_pre(dec_pre),
        .sel_rsv(dec_rsv)
    );

    // sampling while reset is high; last sample before release is kept
    always_comb
    begin
        st_d = st_q;
        if (reset)
        begin
            st_d.oe_n = 1'b1; // pins are inputs during reset
            st_d.valid = 1'b0;
            // only the low bits come from pins; pulls give 00001
            st_d.addr = {PSC_ADDR_HI_ZERO, station_addr_strap[2:0]};
            st_d.mode = mode_strap;
            st_d.mii = dec_mii;
            st_d.rmii = dec_rmii;
            st_d.smii = dec_smii;
            st_d.b2b = dec_b2b;
            st_d.pre = dec_pre;
            st_d.rsv = dec_rsv;
            st_d.fiber = fiber_select;
            // speed pin doubles as far-end fault only in fiber mode
            st_d.fef = fiber_select & speed_strap;
            st_d.ctl = 16'h0000;
            st_d.ctl[PSC_CTL_ISO_BIT] = iso_strap;
            // pull-up is half duplex, so the full-duplex bit is inverted
            st_d.ctl[PSC_CTL_DPX_BIT] = ~duplex_strap;
            st_d.ctl[PSC_CTL_ANEG_BIT] = autoneg_enable_strap & ~fiber_select;
            st_d.adv = PSC_ADV_RST;
            if (fiber_select)
            begin
                // fiber runs at 100 fixed; speed pin means far-end fault here
                st_d.ctl[PSC_CTL_SPEED_BIT] = 1'b1;
            end
            else
            begin
                st_d.ctl[PSC_CTL_SPEED_BIT] = speed_strap;
                st_d.adv[PSC_ADV_100FD_BIT] = speed_strap;
                st_d.adv[PSC_ADV_100HD_BIT] = speed_strap;
            end
        end
        else
        begin
            // after release the pins go back to outputs, values held
            st_d.oe_n = 1'b0;
            st_d.valid = 1'b1;
        end
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge core_clk)
    begin
        if (clk_en)
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state flops
    assign strap_oe_n = st_q.oe_n;
    assign cfg_valid = st_q.valid;
    assign station_addr = st_q.addr;
    assign mode_code = st_q.mode;
    assign mode_mii = st_q.mii;
    assign mode_rmii = st_q.rmii;
    assign mode_smii = st_q.smii;
    assign mode_b2b = st_q.b2b;
    assign mode_pre_restore = st_q.pre;
    assign mode_reserved = st_q.rsv;
    assign fiber_mode = st_q.fiber;
    assign far_end_fault_enable = st_q.fef;
    assign ctl_default = st_q.ctl;
    assign adv_default = st_q.adv;
endmodule

// ==== logic/psc_pkg.sv ====
// Purpose: shared constants for the strap configuration latch
// Assumes: one 20 MHz core clock, synchronous active-high reset
// Notes: field positions refer to the basic control and advertisement words
package psc_pkg;
    localparam int unsigned PSC_CLK_HZ = 20000000; // core clock rate
    localparam int unsigned PSC_ADDR_W = 5; // station address width
    localparam int unsigned PSC_ADDR_PINS = 3; // address bits taken from pins
    localparam logic [1:0] PSC_ADDR_HI_ZERO = 2'h0; // upper address bits always zero
    localparam logic [2:0] PSC_ADDR_PIN_DEF = 3'h1; // pull defaults give address 00001
    localparam int unsigned PSC_MODE_W = 3; // interface select width
    localparam logic [2:0] PSC_MODE_DEF = 3'h0; // mii default
    // control word bit positions
    localparam int unsigned PSC_CTL_SPEED_BIT = 13; // speed select
    localparam int unsigned PSC_CTL_ANEG_BIT = 12; // auto-negotiation enable
    localparam int unsigned PSC_CTL_ISO_BIT = 10; // isolate
    localparam int unsigned PSC_CTL_DPX_BIT = 8; // duplex (1 = full)
    localparam logic [15:0] PSC_CTL_RST = 16'h3000; // 100m, aneg on, half, no isolate
    // advertisement word bit positions for speed capability
    localparam int unsigned PSC_ADV_100FD_BIT = 8; // 100 full
    localparam int unsigned PSC_ADV_100HD_BIT = 7; // 100 half
    localparam int unsigned PSC_ADV_10FD_BIT = 6; // 10 full
    localparam int unsigned PSC_ADV_10HD_BIT = 5; // 10 half
    localparam logic [15:0] PSC_ADV_RST = 16'h01e1; // all caps plus csma selector
    // strap pin defaults (internal pull levels)
    localparam logic PSC_ISO_DEF = 1'b0; // pull-down
    localparam logic PSC_SPEED_DEF = 1'b1; // pull-up
    localparam logic PSC_DPX_DEF = 1'b1; // pull-up, half duplex
    localparam logic PSC_ANEG_DEF = 1'b1; // pull-up
    localparam logic PSC_FIBER_DEF = 1'b0; // copper
    typedef enum logic [2:0] {
        PSC_MII = 3'h0,
        PSC_RMII = 3'h1,
        PSC_SMII = 3'h2,
        PSC_RSV3 = 3'h3,
        PSC_MII_PRE = 3'h4,
        PSC_RMII_B2B = 3'h5,
        PSC_MII_B2B = 3'h6,
        PSC_RSV7 = 3'h7
    } psc_mode_e;
endpackage

// ==== logic/psc_mode_decode.sv ====
// Purpose: decode of the live interface select strap pins
// Assumes: code is the live strap level; the latch registers the flags with it
// Notes: reserved codes raise a flag and select no interface
`timescale 1ns/1ns
module psc_mode_decode
    import psc_pkg::*;
(
    input wire logic [2:0] mode_code, // live select strap levels
    output logic sel_mii, // mii family
    output logic sel_rmii, // rmii family
    output logic sel_smii, // smii
    output logic sel_b2b, // back-to-back variant
    output logic sel_pre, // preamble restore variant
    output logic sel_rsv // reserved code seen
);
    // decode of the select code; codes 4, 5 and 6 raise a family flag plus a variant flag
    always_comb
    begin
        sel_mii = 1'b0;
        sel_rmii = 1'b0;
        sel_smii = 1'b0;
        sel_b2b = 1'b0;
        sel_pre = 1'b0;
        sel_rsv = 1'b0;
        case (psc_mode_e'(mode_code))
            PSC_MII: sel_mii = 1'b1;
            PSC_RMII: sel_rmii = 1'b1;
            PSC_SMII: sel_smii = 1'b1;
            PSC_MII_PRE:
            begin
                sel_mii = 1'b1;
                sel_pre = 1'b1;
            end
            PSC_RMII_B2B:
            begin
                sel_rmii = 1'b1;
                sel_b2b = 1'b1;
            end
            PSC_MII_B2B:
            begin
                sel_mii = 1'b1;
                sel_b2b = 1'b1;
            end
            default: sel_rsv = 1'b1; // reserved codes
        endcase
    end
endmodule

// ==== testbench/psc_strap_latch_assertions.sv ====
// Purpose: port checks for the strap latch
// Assumes: one clock, synchronous reset
// Notes: bound onto every latch instance
`timescale 1ns/1ns
module psc_latch_chk
    import psc_pkg::*;
#(
    parameter int unsigned ADDR_PINS = PSC_ADDR_PINS // strapped address bits
)
(
    input wire logic core_clk, // clock
    input wire logic reset, // sync reset
    input wire logic clk_en, // enable
    input wire logic [ADDR_PINS-1:0] station_addr_strap, // address pins
    input wire logic iso_strap, // isolate pin
    input wire logic strap_oe_n, // pins released when low
    input wire logic cfg_valid, // captured flag
    input wire logic [4:0] station_addr, // address
    input wire logic [2:0] mode_code, // select code
    input wire logic mode_smii, // smii flag
    input wire logic mode_reserved, // reserved flag
    input wire logic fiber_mode, // fiber latched
    input wire logic far_end_fault_enable, // fault enable
    input wire logic [15:0] ctl_default // control word
);
    default clocking cb @(posedge core_clk);
    endclocking
    // an enabled edge with reset high takes the straps
    sequence s_take;
        reset && clk_en;
    endsequence
    // first enabled edge after reset falls
    sequence s_rel;
        reset ##1 !reset && clk_en;
    endsequence
    chk_take_hold: assert property (s_take |=> !cfg_valid && strap_oe_n)
        else $error("pins not held as inputs");
    chk_release_valid: assert property (s_rel |=> cfg_valid && !strap_oe_n)
        else $error("no valid after release");
    chk_addr_take: assert property (s_take |=> station_addr[2:0] == $past(station_addr_strap))
        else $error("address not captured");
    chk_addr_top: assert property (disable iff (reset) cfg_valid |-> station_addr[4:3] == 2'h0)
        else $error("upper address bits set");
    chk_iso_take: assert property (s_take |=> ctl_default[10] == $past(iso_strap))
        else $error("isolate bit not captured");
    chk_held_stable: assert property (disable iff (reset) cfg_valid && !reset
        |=> $stable(ctl_default) && $stable(station_addr) && cfg_valid)
        else $error("config moved after release");
    chk_fiber_aneg: assert property (disable iff (reset) cfg_valid && fiber_mode |-> !ctl_default[12])
        else $error("autoneg on in fiber");
    chk_copper_fef: assert property (disable iff (reset) !fiber_mode |-> !far_end_fault_enable)
        else $error("fault enable in copper");
    chk_mode_flags: assert property (disable iff (reset) cfg_valid |-> mode_smii == (mode_code == 3'h2)
        && mode_reserved == (mode_code[1:0] == 2'h3))
        else $error("mode flags wrong");
endmodule
bind psc_strap_latch psc_latch_chk #(.ADDR_PINS(ADDR_PINS)) i_chk (.core_clk(core_clk),
    .reset(reset), .clk_en(clk_en), .station_addr_strap(station_addr_strap),
    .iso_strap(iso_strap), .strap_oe_n(strap_oe_n), .cfg_valid(cfg_valid),
    .station_addr(station_addr), .mode_code(mode_code), .mode_smii(mode_smii),
    .mode_reserved(mode_reserved), .fiber_mode(fiber_mode),
    .far_end_fault_enable(far_end_fault_enable), .ctl_default(ctl_default));

// ==== testbench/psc_board_model.sv ====
// Purpose: board pulls and mac pins on the strap lines
// Assumes: levels set by the bench
// Notes: released pins toggle so stale values are never seen
`timescale 1ns/1ns
module psc_board_model
(
    input wire logic core_clk, // clock
    input wire logic strap_oe_n, // high while pins are strap inputs
    input wire logic [10:0] level, // pull levels, seen at the pins only while strap_oe_n is not low
    output logic [10:0] pins // levels at the pins
);
    logic [10:0] last_q; // flips every cycle once released
    // after release the pins carry traffic, not straps
    // an unknown enable before the first reset edge counts as strap time
    always @(posedge core_clk)
        last_q <= (strap_oe_n !== 1'b0) ? level : ~last_q;
    assign pins = (strap_oe_n !== 1'b0) ? level : last_q;
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the strap latch
// Assumes: 20 MHz clock, straps from the board model
// Notes: model works on the packed strap word
`timescale 1ns/1ns
module tb_top;
    import psc_pkg::*;
    logic core_clk = 0, reset = 1, clk_en = 1; // clock and controls
    logic [10:0] level = 11'h10e, pins; // addr, mode, iso, speed, dpx, aneg, fiber
    logic [7:0] seed = 8'h22; // lfsr state
    logic strap_oe_n, cfg_valid, fiber_mode, far_end_fault_enable; // flags
    logic mm, mr, ms, mb, mp, mx; // mode flags
    logic [4:0] station_addr; // address
    logic [2:0] mode_code; // code
    logic [15:0] ctl_default, adv_default; // words
    int fail_count = 0, cmp_count = 0; // counters
    psc_board_model i_board (.core_clk(core_clk), .strap_oe_n(strap_oe_n), .level(level),
        .pins(pins));
    psc_strap_latch i_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .station_addr_strap(pins[10:8]), .mode_strap(pins[7:5]), .iso_strap(pins[4]),
        .speed_strap(pins[3]), .duplex_strap(pins[2]), .autoneg_enable_strap(pins[1]),
        .fiber_select(pins[0]), .strap_oe_n(strap_oe_n), .cfg_valid(cfg_valid),
        .station_addr(station_addr), .mode_code(mode_code), .mode_mii(mm), .mode_rmii(mr),
        .mode_smii(ms), .mode_b2b(mb), .mode_pre_restore(mp), .mode_reserved(mx),
        .fiber_mode(fiber_mode), .far_end_fault_enable(far_end_fault_enable),
        .ctl_default(ctl_default), .adv_default(adv_default));
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // reset with given straps, release, let pins toggle, compare with model
    task automatic run_case(input logic [10:0] v);
        int c, f, sp;
        c = v[7:5];
        f = v[0];
        sp = v[3];
        level = v;
        reset = 1;
        repeat (2) @(posedge core_clk);
        #5 chk("hold", {strap_oe_n, cfg_valid}, 2);
        reset = 0;
        repeat (3) @(posedge core_clk);
        #5 chk("addr", station_addr, v[10:8]);
        chk("mode", {mode_code, mm, mr, ms, mb, mp, mx}, {c[2:0], c == 0 || c == 4 || c == 6,
            c == 1 || c == 5, c == 2, c == 5 || c == 6, c == 4, c == 3 || c == 7});
        chk("fiber", {fiber_mode, far_end_fault_enable}, {f[0], f[0] & sp[0]});
        chk("ctl", ctl_default, ((f | sp) << 13) | ((v[1] & !f) << 12) | (v[4] << 10)
            | (!v[2] << 8));
        chk("adv", adv_default, (f | sp) ? 16'h01e1 : 16'h0061);
        chk("done", {strap_oe_n, cfg_valid}, 1);
        $display("case %h done", v);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        run_case(11'h10e);
        run_case(11'h10f);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            run_case({i[2:0], i[2:0], seed[4:0]});
        end
        // frozen clock enable ignores a reset request
        clk_en = 0;
        reset = 1;
        repeat (3) @(posedge core_clk);
        #5 reset = 0;
        clk_en = 1;
        @(posedge core_clk);
        #5 chk("frozen", {cfg_valid, strap_oe_n, station_addr}, 7'h47);
        wrap_up();
    end
    initial
    begin
        #20000;
        fail_count++;
        wrap_up();
    end
endmodule
